// ==== core/pds_top.sv ====
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
module pds_top #(
  parameter int NPUMP      = 3,
  parameter int SEC_CYCLES = pds_pkg::SEC_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst,
  // Level measurement, same clock domain
  input  wire logic [15:0]                 i_level,
  input  wire logic signed [15:0]          i_rate,
  // AXI4-Lite write address and data
  input  wire logic                        i_s_axi_awvalid,
  output logic                             o_s_axi_awready,
  input  wire logic [pds_pkg::AXI_AW-1:0]  i_s_axi_awaddr,
  input  wire logic                        i_s_axi_wvalid,
  output logic                             o_s_axi_wready,
  input  wire logic [pds_pkg::AXI_DW-1:0]  i_s_axi_wdata,
  input  wire logic [3:0]                  i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic                             o_s_axi_bvalid,
  input  wire logic                        i_s_axi_bready,
  output logic [1:0]                       o_s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                        i_s_axi_arvalid,
  output logic                             o_s_axi_arready,
  input  wire logic [pds_pkg::AXI_AW-1:0]  i_s_axi_araddr,
  output logic                             o_s_axi_rvalid,
  input  wire logic                        i_s_axi_rready,
  output logic [pds_pkg::AXI_DW-1:0]       o_s_axi_rdata,
  output logic [1:0]                       o_s_axi_rresp,
  // Relay contacts
  output logic [NPUMP-1:0]                 o_relay,
  output logic                             o_flush_relay
);
  import pds_pkg::*;

  localparam int NG = 2;

  // Refuse pump counts below two or above what the register map can hold
  if (NPUMP < 2 || NPUMP > NP_MAX) begin : g_chk
    $error("NPUMP must be 2 to 4");
  end
  if (SEC_CYCLES < 2) begin : g_chk_sec
    $error("SEC_CYCLES must be at least 2");
  end

  // Configuration registers
  logic [31:0] ctrl_q, rate_q, runon_q, flush_cfg_q, wall_q;
  logic [31:0] on_q    [NPUMP];
  logic [31:0] off_q   [NPUMP];
  logic [31:0] ratio_q [NPUMP];
  logic [31:0] hours_q [NPUMP];
  // Bus state
  logic        aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  // Sequencer state
  logic [NPUMP-1:0] relay_q, sp_q;
  logic [IW-1:0]    lead_q   [NG];
  logic             wc_odd_q [NG];
  logic [IW:0]      vcnt_q   [NG];
  logic [IW:0]      rcnt_q   [NG];
  logic [7:0]       rocyc_q  [NG];
  logic [15:0]      roleft_q [NG];
  logic             roused_q [NG];
  logic [15:0]      seq_q    [NPUMP];
  logic [15:0]      seq_ctr_q;
  logic [31:0]      tick_cnt_q;
  logic             tick_q;
  logic [7:0]       starts_q, fl_left_q;
  logic             flush_q;

  // Field views
  logic [7:0] fn;
  logic       active, backup, ratio_mode, fifo;
  assign fn = ctrl_q[CTRL_FN_LSB +: 8];
  assign active = (ctrl_q[CTRL_LSEL_LSB +: 4] == LSEL_PUMP) && // [R4]
                  (fn >= FN_ALT_ASSIST) && (fn <= FN_FIFO);
  assign backup     = (fn == FN_ALT_BACKUP) || (fn == FN_SR_BACKUP);
  assign ratio_mode = (fn == FN_SR_ASSIST) || (fn == FN_SR_BACKUP);
  assign fifo       = (fn == FN_FIFO);

  // Count of set bits in a pump mask
  function automatic logic [IW:0] popc(input logic [NPUMP-1:0] m);
    popc = '0;
    for (int i = 0; i < NPUMP; i++) popc = popc + (IW+1)'(m[i]);
  endfunction

  // First set bit at or after start, wrapping round the pumps
  function automatic logic [IW-1:0] first_from(
      input logic [NPUMP-1:0] m, input logic [IW-1:0] start);
    int k;
    first_from = start;
    for (int i = NPUMP - 1; i >= 0; i--) begin
      k = (int'(start) + i) % NPUMP;
      if (m[k]) first_from = IW'(k);
    end
  endfunction

  // Address decode shared by read and write paths
  function automatic logic map_ok(input logic [7:0] a, input logic wr);
    logic [7:0] idx;
    idx = {2'h0, a[7:2]} - {2'h0, OFS_ON[7:2]};
    map_ok = (a[1:0] == 2'h0) && ((a <= OFS_WALL) || (!wr &&
             ((a == OFS_STATUS) || ((a >= OFS_HOURS) &&
             (a < OFS_HOURS + 8'(4 * NPUMP))))));
    if (a >= OFS_ON && a < OFS_WALL && (idx % 8'h4) >= 8'(NPUMP))
      map_ok = 1'b0;
  endfunction

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb,
      input logic [31:0] msk);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    merge = merge & msk;
  endfunction

  // One-second tick for hours, run-on, rate and flush timing
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == 32'(SEC_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 32'(SEC_CYCLES - 1)) ? 32'h0 :
                    tick_cnt_q + 32'h1;
    end
  end

  // Write channel: address and data taken in either order
  logic do_wr;
  assign do_wr = !aw_rdy_q && !w_rdy_q && !bvalid_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q  <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (aw_rdy_q && i_s_axi_awvalid) begin
        aw_rdy_q <= 1'b0;
        awaddr_q <= i_s_axi_awaddr;
      end
      if (w_rdy_q && i_s_axi_wvalid) begin
        w_rdy_q <= 1'b0;
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= map_ok(awaddr_q, 1'b1) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q  <= 1'b1;
      end
    end
  end

  // Register file updates
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q      <= CTRL_RST;
      rate_q      <= ZERO_RST;
      runon_q     <= ZERO_RST;
      flush_cfg_q <= ZERO_RST;
      wall_q      <= ZERO_RST;
      for (int p = 0; p < NPUMP; p++) begin
        on_q[p]    <= ZERO_RST;
        off_q[p]   <= ZERO_RST;
        ratio_q[p] <= ZERO_RST;
      end
    end else if (do_wr) begin
      case (awaddr_q)
        OFS_CTRL:  ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q, MSK_CTRL);
        OFS_RATE:  rate_q <= merge(rate_q, wdata_q, wstrb_q, '1);
        OFS_RUNON: runon_q <= merge(runon_q, wdata_q, wstrb_q, MSK_RUNON);
        OFS_FLUSH:
          flush_cfg_q <= merge(flush_cfg_q, wdata_q, wstrb_q, MSK_FLUSH);
        OFS_WALL:  wall_q <= merge(wall_q, wdata_q, wstrb_q, MSK_16);
        default: begin
          for (int p = 0; p < NPUMP; p++) begin
            if (awaddr_q == OFS_ON + 8'(4 * p))
              on_q[p] <= merge(on_q[p], wdata_q, wstrb_q, MSK_16);
            if (awaddr_q == OFS_OFF + 8'(4 * p))
              off_q[p] <= merge(off_q[p], wdata_q, wstrb_q, MSK_16);
            if (awaddr_q == OFS_RATIO + 8'(4 * p)) // [R7]
              ratio_q[p] <= merge(ratio_q[p], wdata_q, wstrb_q, MSK_8);
          end
        end
      endcase
    end
  end

  // Read channel with one-cycle answer
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_s_axi_araddr)
      OFS_CTRL:   rd_mux = ctrl_q;
      OFS_RATE:   rd_mux = rate_q;
      OFS_RUNON:  rd_mux = runon_q;
      OFS_FLUSH:  rd_mux = flush_cfg_q;
      OFS_WALL:   rd_mux = wall_q;
      OFS_STATUS: rd_mux = {8'h00, starts_q, 2'h0, lead_q[1], 2'h0,
                            lead_q[0], 3'h0, flush_q,
                            4'(relay_q)};
      default: begin
        for (int p = 0; p < NPUMP; p++) begin
          if (i_s_axi_araddr == OFS_ON + 8'(4 * p))    rd_mux = on_q[p];
          if (i_s_axi_araddr == OFS_OFF + 8'(4 * p))   rd_mux = off_q[p];
          if (i_s_axi_araddr == OFS_RATIO + 8'(4 * p)) rd_mux = ratio_q[p];
          if (i_s_axi_araddr == OFS_HOURS + 8'(4 * p)) rd_mux = hours_q[p];
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ar_rdy_q && i_s_axi_arvalid) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q  <= map_ok(i_s_axi_araddr, 1'b0) ? rd_mux : 32'h0;
      rresp_q  <= map_ok(i_s_axi_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && i_s_axi_rready) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Setpoint latches with hysteresis; wall cling narrows the band
  logic up;
  assign up = ctrl_q[CTRL_UP_BIT];
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sp_q <= '0;
    end else begin
      for (int p = 0; p < NPUMP; p++) begin
        logic [16:0] on_e, off_e, v;
        int g;
        g    = int'(ctrl_q[CTRL_GRP_LSB + p]);
        v    = (ctrl_q[CTRL_WALL_BIT] && wc_odd_q[g]) ?
               {1'b0, wall_q[15:0]} : 17'h0; // [R14]
        on_e  = up ? {1'b0, on_q[p][15:0]} + v :
                     {1'b0, on_q[p][15:0]} - v;
        off_e = up ? {1'b0, off_q[p][15:0]} - v :
                     {1'b0, off_q[p][15:0]} + v;
        if (up ? ({1'b0, i_level} <= on_e) : ({1'b0, i_level} >= on_e))
          sp_q[p] <= 1'b1; // [R17]
        else if (up ? ({1'b0, i_level} >= off_e) :
                      ({1'b0, i_level} <= off_e))
          sp_q[p] <= 1'b0; // [R17]
      end
    end
  end

  // Per-group demand and choice of pump to start or stop
  logic [NPUMP-1:0] mem [NG];
  logic [NPUMP-1:0] run [NG];
  logic [NPUMP-1:0] cand [NG];
  logic [IW:0]      want [NG];
  logic             grow [NG];
  logic             shrink [NG];
  logic [IW-1:0]    r_idx [NG];
  logic             r_found [NG];
  logic [IW-1:0]    old_idx [NG];
  logic [IW-1:0]    new_idx [NG];
  logic [IW-1:0]    st_idx [NG];
  logic [IW-1:0]    sp_idx [NG];
  logic [NPUMP*HW-1:0] hours_flat;
  logic [NPUMP*RW-1:0] ratio_flat;

  always_comb begin
    for (int p = 0; p < NPUMP; p++) begin
      hours_flat[p*HW +: HW] = hours_q[p];
      ratio_flat[p*RW +: RW] = ratio_q[p][7:0];
    end
    for (int g = 0; g < NG; g++) begin
      for (int p = 0; p < NPUMP; p++)
        mem[g][p] = (int'(ctrl_q[CTRL_GRP_LSB + p]) == g); // [R15]
      run[g]  = relay_q & mem[g];
      want[g] = ctrl_q[CTRL_RATE_BIT] ? rcnt_q[g] :
                popc(sp_q & mem[g]);
      grow[g]   = backup ? (want[g] > vcnt_q[g]) : // [R9]
                           (want[g] > popc(run[g]));
      shrink[g] = backup ? (want[g] == '0 && run[g] != '0) :
                           (want[g] < popc(run[g]));
      cand[g] = grow[g] ? (mem[g] & ~run[g]) : run[g];
      old_idx[g] = '0;
      new_idx[g] = '0;
      for (int p = NPUMP - 1; p >= 0; p--)
        if (run[g][p] && (seq_q[p] - seq_q[old_idx[g]]) > 16'h7FFF)
          old_idx[g] = IW'(p);
      for (int p = 0; p < NPUMP; p++) begin
        if (!run[g][old_idx[g]] || (run[g][p] && seq_q[p] < seq_q[old_idx[g]]))
          old_idx[g] = run[g][p] ? IW'(p) : old_idx[g];
        if (run[g][p] && seq_q[p] >= seq_q[new_idx[g]])
          new_idx[g] = IW'(p);
        else if (run[g][p] && !run[g][new_idx[g]])
          new_idx[g] = IW'(p);
      end
      // Alternate backup starts from a fresh pump past the last one; ratio modes take the ratio pick
      st_idx[g] = (ratio_mode && r_found[g]) ? r_idx[g] : // [R5]
                  first_from(cand[g], backup && run[g] != '0 ?
                    IW'((int'(new_idx[g]) + 1) % NPUMP) : lead_q[g]);
      sp_idx[g] = fifo ? old_idx[g] :                         // [R11]
                  (ratio_mode ? r_idx[g] : new_idx[g]);
    end
  end

  for (genvar g = 0; g < NG; g++) begin : g_pick
    pds_ratio_pick #(.NP(NPUMP)) u_pick (
      .i_hours    (hours_flat),
      .i_ratio    (ratio_flat),
      .i_cand     (cand[g]),
      .i_pick_max (!grow[g]),
      .o_idx      (r_idx[g]),
      .o_found    (r_found[g])
    );
  end

  // Relay sequencing, rotation, run-on and rate stepping
  logic any_start;
  always_comb begin
    any_start = 1'b0;
    for (int g = 0; g < NG; g++)
      if (active && grow[g] && cand[g] != '0) any_start = 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      relay_q   <= '0;
      seq_ctr_q <= 16'h0000;
      for (int p = 0; p < NPUMP; p++) seq_q[p] <= 16'h0000;
      for (int g = 0; g < NG; g++) begin
        lead_q[g]   <= '0;
        wc_odd_q[g] <= 1'b0;
        vcnt_q[g]   <= '0;
        rcnt_q[g]   <= '0;
        rocyc_q[g]  <= 8'h00;
        roleft_q[g] <= 16'h0000;
        roused_q[g] <= 1'b0;
      end
    end else if (!active) begin
      relay_q <= '0; // [R4]
      for (int g = 0; g < NG; g++) vcnt_q[g] <= '0;
    end else begin
      if (any_start) seq_ctr_q <= seq_ctr_q + 16'h1;
      for (int g = 0; g < NG; g++) begin
        // Rate mode adds one pump per tick while rate falls short
        if (popc(sp_q & mem[g]) == '0)
          rcnt_q[g] <= '0;
        else if (tick_q && rcnt_q[g] < popc(mem[g]) &&
                 (up ? (i_rate < $signed(rate_q[15:0])) :
                       (-i_rate < $signed(rate_q[31:16]))))
          rcnt_q[g] <= rcnt_q[g] + (IW+1)'(1); // [R12]
        if (grow[g] && cand[g] != '0) begin
          if (backup) begin
            for (int p = 0; p < NPUMP; p++) // [R2] [R8] [R9]
              if (mem[g][p]) relay_q[p] <= (IW'(p) == st_idx[g]);
            vcnt_q[g] <= vcnt_q[g] + (IW+1)'(1);
          end else begin
            relay_q[st_idx[g]] <= 1'b1; // [R10] [R18]
          end
          seq_q[st_idx[g]] <= seq_ctr_q;
        end else if (shrink[g]) begin
          // Run-on window is decided once, when demand first ends
          if (want[g] == '0 && !roused_q[g]) begin
            roused_q[g] <= 1'b1;
            roleft_q[g] <= (runon_q[7:0] != 8'h00 &&
                            rocyc_q[g] + 8'h1 >= runon_q[7:0]) ?
                           runon_q[RUNON_DUR_LSB +: 16] : 16'h0; // [R13]
          end else if (want[g] == '0 && roleft_q[g] != 16'h0) begin
            if (tick_q) roleft_q[g] <= roleft_q[g] - 16'h1; // [R13]
          end else begin
            relay_q[sp_idx[g]] <= 1'b0; // [R6] [R11] [R17]
            if (run[g] == (NPUMP'(1) << sp_idx[g])) begin
              // Level cycle complete: advance the lead relay
              lead_q[g] <= first_from(mem[g],
                           IW'((int'(lead_q[g]) + 1) % NPUMP)); // [R1] [R3] [R19]
              wc_odd_q[g] <= !wc_odd_q[g]; // [R14]
              vcnt_q[g]   <= '0;
              roused_q[g] <= 1'b0;
              rocyc_q[g]  <= (rocyc_q[g] + 8'h1 >= runon_q[7:0]) ?
                             8'h00 : rocyc_q[g] + 8'h1;
            end
          end
        end else if (want[g] != '0) begin
          roused_q[g] <= 1'b0;
        end
      end
    end
  end

  // Run hours per pump and flush device by start count
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int p = 0; p < NPUMP; p++) hours_q[p] <= 32'h0000_0000;
      starts_q  <= 8'h00;
      flush_q   <= 1'b0;
      fl_left_q <= 8'h00;
    end else begin
      for (int p = 0; p < NPUMP; p++)
        if (tick_q && relay_q[p]) hours_q[p] <= hours_q[p] + 32'h1; // [R5]
      if (any_start && flush_cfg_q[7:0] != 8'h00) begin
        if (starts_q + 8'h1 >= flush_cfg_q[7:0]) begin
          starts_q  <= 8'h00;
          flush_q   <= 1'b1; // [R16]
          fl_left_q <= flush_cfg_q[FLUSH_DUR_LSB +: 8];
        end else begin
          starts_q <= starts_q + 8'h1;
        end
      end else if (flush_q && tick_q) begin
        if (fl_left_q <= 8'h1) flush_q <= 1'b0;
        fl_left_q <= fl_left_q - 8'h1;
      end
    end
  end

  // Outputs straight from flops
  assign o_s_axi_awready = aw_rdy_q;
  assign o_s_axi_wready  = w_rdy_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = ar_rdy_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;
  assign o_relay         = relay_q;
  assign o_flush_relay   = flush_q;
endmodule // pds_top

// ==== core/pds_pkg.sv ====
// Functional notes
// R1: Backup alternation moves lead each level cycle
// R2: Alternate backup closes one group relay only
// R3: Setpoint-to-relay mapping held and rotated internally
// R4: Duty logic acts only when logic select is two
// R5: Ratio assist picks lead from hours and ratios
// R6: Next start/stop pump follows demanded/actual ratio
// R7: Software gives ratios as percent of run
// R8: Ratio backup allows only one closed relay
// R9: Ratio backup start opens previous running relay
// R10: FIFO starts pumps like alternate duty assist
// R11: FIFO stops earliest started pump first
// R12: Rate pumping adds pumps until rate reached
// R13: Run-on keeps pump running extra time
// R14: Wall cling varies setpoints each cycle
// R15: Two independent alternate pump groups supported
// R16: Flush relay fires after configured start count
// R17: Relay closes at start, opens at stop
// R18: Alternate assist rotates lead, pumps run together
// R19: Mapping advances one relay per cycle
package pds_pkg;
  // Bus and pump table geometry
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int NP_MAX = 4;
  localparam int IW     = 2;
  localparam int HW     = 32;
  localparam int RW     = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RATE   = 8'h04;
  localparam logic [7:0] OFS_RUNON  = 8'h08;
  localparam logic [7:0] OFS_FLUSH  = 8'h0C;
  localparam logic [7:0] OFS_ON     = 8'h10;
  localparam logic [7:0] OFS_OFF    = 8'h20;
  localparam logic [7:0] OFS_RATIO  = 8'h30;
  localparam logic [7:0] OFS_WALL   = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h44;
  localparam logic [7:0] OFS_HOURS  = 8'h50;
  // Field positions in control, run-on and flush words
  localparam int CTRL_FN_LSB   = 0;
  localparam int CTRL_LSEL_LSB = 8;
  localparam int CTRL_RATE_BIT = 12;
  localparam int CTRL_WALL_BIT = 13;
  localparam int CTRL_UP_BIT   = 14;
  localparam int CTRL_GRP_LSB  = 16;
  localparam int RUNON_DUR_LSB = 8;
  localparam int FLUSH_DUR_LSB = 8;
  // Writable bit masks; other bits read zero
  localparam logic [31:0] MSK_CTRL  = 32'h000F_7FFF;
  localparam logic [31:0] MSK_RUNON = 32'h00FF_FFFF;
  localparam logic [31:0] MSK_FLUSH = 32'h0000_FFFF;
  localparam logic [31:0] MSK_16    = 32'h0000_FFFF;
  localparam logic [31:0] MSK_8     = 32'h0000_00FF;
  // Reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0200;
  localparam logic [31:0] ZERO_RST  = 32'h0000_0000;
  // Relay function and logic select codes
  localparam logic [7:0] FN_ALT_ASSIST  = 8'h34;
  localparam logic [7:0] FN_ALT_BACKUP  = 8'h35;
  localparam logic [7:0] FN_SR_ASSIST   = 8'h36;
  localparam logic [7:0] FN_SR_BACKUP   = 8'h37;
  localparam logic [7:0] FN_FIFO        = 8'h38;
  localparam logic [3:0] LSEL_PUMP      = 4'h2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing: one second tick at 10 MHz
  localparam int CLK_HZ         = 10_000_000;
  localparam int TICK_S         = 1;
  localparam int SEC_CYCLES_DEF = CLK_HZ * TICK_S;
endpackage

// ==== core/pds_ratio_pick.sv ====
`timescale 1ns/100ps
// Picks the candidate pump whose hours-to-ratio share is lowest
// (start) or highest (stop); cross products avoid a divider.
module pds_ratio_pick #(
  parameter int NP = 3
) (
  // Pump data
  input  wire logic [NP*pds_pkg::HW-1:0] i_hours,
  input  wire logic [NP*pds_pkg::RW-1:0] i_ratio,
  input  wire logic [NP-1:0]             i_cand,
  input  wire logic                      i_pick_max,
  // Choice
  output logic      [pds_pkg::IW-1:0]    o_idx,
  output logic                           o_found
);
  import pds_pkg::*;

  // Linear scan keeps area small; NP is at most four
  always_comb begin
    logic [HW+RW-1:0] lhs;
    logic [HW+RW-1:0] rhs;
    logic [IW-1:0]    best;
    lhs  = '0;
    rhs  = '0;
    best = '0;
    o_found = 1'b0;
    for (int i = 0; i < NP; i++) begin
      lhs = i_hours[i*HW +: HW] * i_ratio[best*RW +: RW];
      rhs = i_hours[best*HW +: HW] * i_ratio[i*RW +: RW];
      if (i_cand[i] && (!o_found ||
          (i_pick_max ? (lhs > rhs) : (lhs < rhs)))) begin // [R6]
        best    = IW'(i);
        o_found = 1'b1;
      end
    end
    o_idx = best;
  end
endmodule // pds_ratio_pick

// ==== testbench/pds_props.sv ====
`timescale 1ns/100ps
// Bus handshake and relay pattern checks at the top ports
module pds_props import pds_pkg::*; #(parameter int NPUMP = 3) (
  input wire logic i_ref_clk, i_rst, i_s_axi_awvalid, i_s_axi_wvalid,
  input wire logic i_s_axi_arvalid, i_s_axi_rready,
  input wire logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid,
  input wire logic o_s_axi_arready, o_s_axi_rvalid,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic [31:0] i_s_axi_wdata, o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_bresp, o_s_axi_rresp,
  input wire logic [NPUMP-1:0] o_relay
);
  logic [7:0]  wa_q;
  logic [31:0] wd_q;
  logic [31:0] ctrl_q;
  // Shadow control word; one edge late, so only slow relations use it
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wa_q <= 8'h00;
      wd_q <= 32'h0;
      ctrl_q <= CTRL_RST;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) wa_q <= i_s_axi_awaddr;
      if (i_s_axi_wvalid && o_s_axi_wready) wd_q <= i_s_axi_wdata;
      if (o_s_axi_bvalid && o_s_axi_bresp == RESP_OKAY && wa_q == OFS_CTRL)
        ctrl_q <= wd_q & MSK_CTRL;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready &&
    i_s_axi_wvalid && o_s_axi_wready |-> ##2 o_s_axi_bvalid)
    else $error("no b");
  a_write_block: assert property (o_s_axi_bvalid |->
    !o_s_axi_awready && !o_s_axi_wready) else $error("ready during b");
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
    |=> o_s_axi_rvalid) else $error("no r");
  a_read_block: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("arready during r");
  a_read_drop: assert property (o_s_axi_rvalid && i_s_axi_rready
    |=> !o_s_axi_rvalid && o_s_axi_arready) else $error("r not ended");
  a_refused_zero: assert property (o_s_axi_rvalid && o_s_axi_rresp ==
    RESP_SLVERR |-> o_s_axi_rdata == 32'h0) else $error("refused data");
  a_backup_single: assert property (ctrl_q[11:8] == LSEL_PUMP &&
    (ctrl_q[7:0] == FN_ALT_BACKUP || ctrl_q[7:0] == FN_SR_BACKUP) |->
    $countones(o_relay) <= 1) else $error("two relays in backup");
  a_refuse_open: assert property (ctrl_q[11:8] != LSEL_PUMP
    |=> o_relay == '0) else $error("relay closed with logic off");
endmodule // pds_props
bind pds_top pds_props #(.NPUMP(NPUMP)) pds_props_i (.i_ref_clk, .i_rst,
  .i_s_axi_awvalid, .i_s_axi_wvalid, .i_s_axi_arvalid, .i_s_axi_rready,
  .o_s_axi_awready, .o_s_axi_wready, .o_s_axi_bvalid, .o_s_axi_arready,
  .o_s_axi_rvalid, .i_s_axi_awaddr, .i_s_axi_wdata, .o_s_axi_rdata,
  .o_s_axi_bresp, .o_s_axi_rresp, .o_relay);

// ==== testbench/pds_well.sv ====
`timescale 1ns/100ps
// Wet well: level set by the bench, rate drops as pumps run
module pds_well #(parameter int NP = 3) (
  // Pump contacts and bench level
  input  wire logic [NP-1:0] i_relay,
  input  wire logic [15:0]   i_target,
  // Measured level and rate
  output logic [15:0]        o_level,
  output logic signed [15:0] o_rate
);
  // Inflow 10, each running pump takes 20
  assign o_level = i_target;
  assign o_rate  = 16'(16'sh000A - 16'sh0014 * 16'($countones(i_relay)));
endmodule // pds_well

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
  import pds_pkg::*;
  logic clk, rst, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv, fl;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdt;
  logic [1:0]  brs, rrs;
  logic [2:0]  rly;
  logic [15:0] tgt, lev;
  logic signed [15:0] rate;
  int n_mismatch, comparisons;
  pds_top #(.NPUMP(3), .SEC_CYCLES(20)) pds_top_i (.i_ref_clk(clk),
    .i_rst(rst), .i_level(lev), .i_rate(rate), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr_r), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(brs),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_s_axi_rdata(rdt),
    .o_s_axi_rresp(rrs), .o_relay(rly), .o_flush_relay(fl));
  pds_well #(.NP(3)) pds_well_i (.i_relay(rly), .i_target(tgt),
    .o_level(lev), .o_rate(rate));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Address and data offered together, bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wr_r) wv <= 1'h0;
    end while (!bv);
    bry <= 1'h0;
    chk("bresp", {30'h0, brs}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge clk);
    ara <= a; arv <= 1'h1; rry <= 1'h1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rry <= 1'h0;
    chk("rdata", rdt, e);
    chk("rresp", {30'h0, rrs}, {30'h0, er});
  endtask
  // Level change, then time for latch, relay and one start per clock
  task automatic lvl(input logic [15:0] v, input logic [2:0] e);
    @(posedge clk);
    tgt <= v;
    repeat (6) @(posedge clk);
    chk("relay", {29'h0, rly}, {29'h0, e});
  endtask
  task automatic setup(input logic [7:0] fn, input logic [3:0] ls);
    rst <= 1'h1;
    tgt <= 16'h0000;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int p = 0; p < 3; p++) begin
      wr(OFS_ON + 8'(4 * p), 32'(16'h0064 * 16'(p + 1)), RESP_OKAY);
      wr(OFS_OFF + 8'(4 * p), 32'(16'h0050 - 16'h0014 * 16'(p)), RESP_OKAY);
      wr(OFS_RATIO + 8'(4 * p), (p == 2) ? 32'h32 : 32'h19, RESP_OKAY);
    end
    wr(OFS_FLUSH, 32'h0000_0203, RESP_OKAY);
    wr(OFS_CTRL, {20'h0, ls, fn}, RESP_OKAY);
  endtask
  initial begin
    {awv, wv, bry, arv, rry} = 5'h0;
    {awa, ara, wd, tgt} = 64'h0;
    rst = 1'h1;
    n_mismatch = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
    rd(8'hFC, 32'h0, RESP_SLVERR);
    wr(OFS_STATUS, 32'h1, RESP_SLVERR);
    setup(FN_ALT_ASSIST, LSEL_PUMP);
    lvl(16'h0096, 3'h1);
    lvl(16'h00FA, 3'h3);
    lvl(16'h015E, 3'h7);
    repeat (3) @(posedge clk);
    chk("flush", {31'h0, fl}, 32'h1);
    lvl(16'h0046, 3'h3);
    lvl(16'h000A, 3'h0);
    lvl(16'h0096, 3'h2);
    lvl(16'h00FA, 3'h6);
    wr(OFS_RUNON, 32'h0000_0201, RESP_OKAY);
    lvl(16'h000A, 3'h6);
    repeat (40) @(posedge clk);
    chk("runon", {29'h0, rly}, 32'h0);
    setup(FN_ALT_BACKUP, LSEL_PUMP);
    lvl(16'h0096, 3'h1);
    lvl(16'h00FA, 3'h2);
    lvl(16'h015E, 3'h4);
    lvl(16'h000A, 3'h0);
    lvl(16'h0096, 3'h2);
    lvl(16'h00FA, 3'h4);
    setup(FN_FIFO, LSEL_PUMP);
    lvl(16'h015E, 3'h7);
    lvl(16'h0046, 3'h6);
    lvl(16'h0032, 3'h4);
    setup(FN_SR_BACKUP, LSEL_PUMP);
    lvl(16'h0096, 3'h1);
    lvl(16'h00FA, 3'h2);
    chk("single", 32'($countones(rly)), 32'h1);
    setup(FN_ALT_ASSIST, 4'h3);
    lvl(16'h015E, 3'h0);
    final_report();
  end
  // Whole run needs about 480 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("MISMATCH watchdog expected done seen hang");
    final_report();
  end
endmodule // tb
